/* File: logic/sfceg_edge_gen.sv */
// module: fast sensor clock edge generator with register port
`timescale 1ns/100ps

// How it works
// - six fast clocks, programmable rise and fall
// - edges sit on one of 48 taps
// - first pair second output inverts the first
// - second pair second output inverts the first
// - last-stage, reset-gate, clamp own edge registers
// - first pair runs x1, x2 or x4
// - second pair runs x1, x2 or x4
// - other four clocks limited to x1/x2
// - two settings banks, switched by the control set select bit
// - periods derived from master period
// - single rate edges at taps 0..47
// - double rate edges at taps 0..23
// - quadruple rate edges at taps 0..11
// - falling edges use same ranges
// - outputs other than the reference clock held low until enable set
module sfceg_edge_gen (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [sfceg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sfceg_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [sfceg_pkg::DATA_W-1:0] rdata_out,
  output logic internal_reference_clock_out,
  output logic phase_clock_one_out,
  output logic phase_clock_one_inverted_out,
  output logic phase_clock_two_out,
  output logic phase_clock_two_inverted_out,
  output logic last_stage_clock_a_out,
  output logic last_stage_clock_b_out,
  output logic reset_gate_clock_out,
  output logic clamp_pulse_clock_out
);
  import sfceg_pkg::*;

  // ****************
  // helpers
  // ****************
  // fold the tap index into the current sub-period
  function automatic logic [TAP_W-1:0] phase_of(input logic [TAP_W-1:0] tap, input logic [1:0] rate);
    logic [TAP_W-1:0] p;
    p = tap;
    if (rate == SFCEG_RATE_X2) begin
      if (tap >= HALF_TAPS) begin
        p = tap - HALF_TAPS;
      end
    end else if (rate == SFCEG_RATE_X4) begin
      if (tap >= HALF_TAPS + QUARTER_TAPS) begin
        p = tap - HALF_TAPS - QUARTER_TAPS;
      end else if (tap >= HALF_TAPS) begin
        p = tap - HALF_TAPS;
      end else if (tap >= QUARTER_TAPS) begin
        p = tap - QUARTER_TAPS;
      end
    end
    return p;
  endfunction

  // channel register index from an address, or CHAN_COUNT when outside the block
  function automatic int chan_of(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    int c;
    c = CHAN_COUNT;
    if (a >= base && a < base + ADDR_W'(CHAN_COUNT)) begin
      c = int'(a - base);
    end
    return c;
  endfunction

  // effective rate of a channel; code 3 falls back to x1 on a pair and to x2 elsewhere
  function automatic logic [1:0] rate_of(input logic [1:0] code, input logic x4_ok);
    logic [1:0] r;
    r = SFCEG_RATE_X2;
    if (x4_ok) begin
      case (code)
        SFCEG_RATE_X2: r = SFCEG_RATE_X2;
        SFCEG_RATE_X4: r = SFCEG_RATE_X4;
        default: r = SFCEG_RATE_X1;
      endcase
    end else if (code == SFCEG_RATE_X1) begin
      r = SFCEG_RATE_X1;
    end
    return r;
  endfunction

  // next level of one channel; the inverse outputs reuse it so a pair cannot drift apart
  function automatic logic next_level(input logic en, input logic hit_rise, input logic hit_fall, input logic level);
    logic n;
    n = level;
    if (!en) begin
      n = 1'b0;
    end else if (hit_rise) begin
      n = 1'b1;
    end else if (hit_fall) begin
      n = 1'b0;
    end
    return n;
  endfunction

  // ****************
  // registers
  // ****************
  logic [DATA_W-1:0] ctrl_reg;
  sfceg_chan_t cfg_reg [SET_COUNT][CHAN_COUNT];
  sfceg_chan_t act_reg [CHAN_COUNT];
  logic act_set_reg;
  logic act_en_reg;
  logic [TAP_W-1:0] tap_reg;
  logic [CHAN_COUNT-1:0] level_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic boundary;
  logic [DATA_W-1:0] status_word;
  int wr_ch1;
  int wr_ch2;
  int rd_ch1;
  int rd_ch2;

  // the last tap is where every new setting is taken
  assign boundary = (tap_reg == TAP_LAST);
  assign wr_ch1 = chan_of(addr_in, SET_X1_BASE);
  assign wr_ch2 = chan_of(addr_in, SET_X2_BASE);
  // reads and writes share one decode of the channel window
  assign rd_ch1 = wr_ch1;
  assign rd_ch2 = wr_ch2;

  // the whole software side is this port; nothing else reconfigures the block
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_in && addr_in == CTRL_ADDR) begin
      ctrl_reg <= wdata_in;
    end
  end

  // two settings banks, at SET_X1_BASE and SET_X2_BASE; the control set select bit picks the active one
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int s = 0; s < SET_COUNT; s++) begin
        for (int c = 0; c < CHAN_COUNT; c++) begin
          cfg_reg[s][c] <= CHAN_RESET;
        end
      end
    end else if (wr_in) begin
      if (wr_ch1 < CHAN_COUNT) begin
        cfg_reg[0][wr_ch1] <= sfceg_chan_t'(wdata_in[13:0]);
      end else if (wr_ch2 < CHAN_COUNT) begin
        cfg_reg[1][wr_ch2] <= sfceg_chan_t'(wdata_in[13:0]);
      end
    end
  end

  // ****************
  // tap counter, one master period is 48 taps
  // ****************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // start on the last tap so the first edge after release opens a whole period
      tap_reg <= TAP_LAST;
    end else if (boundary) begin
      tap_reg <= '0;
    end else begin
      tap_reg <= tap_reg + 6'h01;
    end
  end

  // reference edge marks the start of every master period
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      internal_reference_clock_out <= 1'b0;
    end else begin
      internal_reference_clock_out <= (tap_reg < HALF_TAPS - 6'h01) || boundary;
    end
  end

  // ****************
  // settings take effect only between periods
  // ****************
  // mid-period updates could truncate a pulse; this costs up to one period of latency
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_set_reg <= 1'b0;
    end else if (boundary) begin
      act_set_reg <= ctrl_reg[CTRL_SET_SEL_BIT];
    end
  end

  // enable waits for the boundary too, so the first pulse out is whole
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_en_reg <= 1'b0;
    end else if (boundary) begin
      act_en_reg <= ctrl_reg[CTRL_OUT_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < CHAN_COUNT; c++) begin
        act_reg[c] <= CHAN_RESET;
      end
    end else if (boundary) begin
      for (int c = 0; c < CHAN_COUNT; c++) begin
        act_reg[c] <= cfg_reg[ctrl_reg[CTRL_SET_SEL_BIT]][c];
      end
    end
  end

  // ****************
  // per-channel edge placement
  // ****************
  genvar g;
  generate
    for (g = 0; g < CHAN_COUNT; g++) begin : g_chan
      logic [1:0] rate;
      logic [TAP_W-1:0] phase;
      logic rise_hit;
      logic fall_hit;
      // only the phase pairs may run x4; others cap at x2
      assign rate = rate_of(act_reg[g].rate, (g == CH_PHASE_ONE) || (g == CH_PHASE_TWO));
      assign phase = phase_of(tap_reg, rate);
      // a setting past the range of its rate never matches, so that edge is dropped
      assign rise_hit = (phase == act_reg[g].rise);
      assign fall_hit = (phase == act_reg[g].fall);
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          level_reg[g] <= 1'b0;
        end else begin
          level_reg[g] <= next_level(act_en_reg, rise_hit, fall_hit, level_reg[g]);
        end
      end
    end
  endgenerate

  // ****************
  // outputs
  // ****************
  always_comb begin
    phase_clock_one_out = level_reg[CH_PHASE_ONE];
    phase_clock_two_out = level_reg[CH_PHASE_TWO];
    last_stage_clock_a_out = level_reg[CH_LAST_A];
    last_stage_clock_b_out = level_reg[CH_LAST_B];
    reset_gate_clock_out = level_reg[CH_RESET_GATE];
    clamp_pulse_clock_out = level_reg[CH_CLAMP];
  end

  // inverse outputs stay low while locked, like the rest
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_clock_one_inverted_out <= 1'b0;
    end else begin
      phase_clock_one_inverted_out <= act_en_reg && !next_level(act_en_reg, g_chan[CH_PHASE_ONE].rise_hit,
        g_chan[CH_PHASE_ONE].fall_hit, level_reg[CH_PHASE_ONE]);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_clock_two_inverted_out <= 1'b0;
    end else begin
      phase_clock_two_inverted_out <= act_en_reg && !next_level(act_en_reg, g_chan[CH_PHASE_TWO].rise_hit,
        g_chan[CH_PHASE_TWO].fall_hit, level_reg[CH_PHASE_TWO]);
    end
  end

  // ****************
  // read port
  // ****************
  // status is read-only; a write to it is ignored
  always_comb begin
    status_word = '0;
    status_word[STATUS_TAP_LSB +: TAP_W] = tap_reg;
    status_word[STATUS_LEVEL_LSB +: CHAN_COUNT] = level_reg;
    status_word[STATUS_SET_BIT] = act_set_reg;
    status_word[STATUS_EN_BIT] = act_en_reg;
  end

  // zero outside the cycle after a read keeps a shared bus quiet
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
    end else if (rd_in) begin
      if (addr_in == CTRL_ADDR) begin
        rdata_reg <= ctrl_reg;
      end else if (addr_in == STATUS_ADDR) begin
        rdata_reg <= status_word;
      end else if (rd_ch1 < CHAN_COUNT) begin
        rdata_reg <= {6'h00, cfg_reg[0][rd_ch1]};
      end else if (rd_ch2 < CHAN_COUNT) begin
        rdata_reg <= {6'h00, cfg_reg[1][rd_ch2]};
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_out = rdata_reg;
endmodule // sfceg_edge_gen

/* File: logic/sfceg_pkg.sv */
// package: constants and types of the sensor fast clock edge generator
package sfceg_pkg;
  // ****************
  // geometry
  // ****************
  localparam int TAP_COUNT = 48;
  localparam int TAP_W = 6;
  localparam int CHAN_COUNT = 6;
  localparam int SET_COUNT = 2;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 20;
  localparam int CLK_HZ = 50000000;
  localparam int TAP_CLOCK_NS = 1000000000 / CLK_HZ;
  localparam logic [TAP_W-1:0] TAP_LAST = 6'h2F;
  localparam logic [TAP_W-1:0] HALF_TAPS = 6'h18;
  localparam logic [TAP_W-1:0] QUARTER_TAPS = 6'h0C;

  // ****************
  // register map
  // ****************
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 10'h002;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h003;
  localparam logic [ADDR_W-1:0] SET_X1_BASE = 10'h010;
  localparam logic [ADDR_W-1:0] SET_X2_BASE = 10'h020;
  localparam int CTRL_SET_SEL_BIT = 0;
  localparam int CTRL_OUT_EN_BIT = 10;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 6;
  localparam int RATE_LSB = 12;
  localparam int STATUS_TAP_LSB = 0;
  localparam int STATUS_LEVEL_LSB = 8;
  localparam int STATUS_SET_BIT = 14;
  localparam int STATUS_EN_BIT = 15;
  localparam logic [DATA_W-1:0] CTRL_RESET = 20'h00000;
  localparam logic [13:0] CHAN_RESET = 14'h0000;

  // ****************
  // channel order and rates
  // ****************
  localparam int CH_PHASE_ONE = 0;
  localparam int CH_PHASE_TWO = 1;
  localparam int CH_LAST_A = 2;
  localparam int CH_LAST_B = 3;
  localparam int CH_RESET_GATE = 4;
  localparam int CH_CLAMP = 5;

  typedef enum logic [1:0] {
    SFCEG_RATE_X1 = 2'h0,
    SFCEG_RATE_X2 = 2'h1,
    SFCEG_RATE_X4 = 2'h2
  } sfceg_rate_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [TAP_W-1:0] fall;
    logic [TAP_W-1:0] rise;
  } sfceg_chan_t;
endpackage

/* File: tb/sfceg_edge_gen_chk.sv */
// checker: port relations of the edge generator
`timescale 1ns/100ps
module sfceg_edge_gen_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] addr_in,
  input wire logic rd_in,
  input wire logic [19:0] rdata_out,
  input wire logic internal_reference_clock_out,
  input wire logic phase_clock_one_out,
  input wire logic phase_clock_one_inverted_out,
  input wire logic phase_clock_two_out,
  input wire logic phase_clock_two_inverted_out,
  input wire logic last_stage_clock_a_out,
  input wire logic clamp_pulse_clock_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ****************
  // sequences and properties
  // ****************
  sequence s_dark;
    (!phase_clock_one_out && !phase_clock_two_out && !last_stage_clock_a_out && !clamp_pulse_clock_out) [*8];
  endsequence
  sequence s_ref_rise;
    $rose(internal_reference_clock_out);
  endsequence
  property p_lock;
    $fell(rst_in) |-> s_dark;
  endproperty
  property p_inv1;
    phase_clock_one_inverted_out |-> !phase_clock_one_out;
  endproperty
  property p_inv2;
    phase_clock_two_inverted_out |-> !phase_clock_two_out;
  endproperty
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 20'h00000;
  endproperty
  property p_rd_unmap;
    rd_in && addr_in == 10'h3FF |=> rdata_out == 20'h00000;
  endproperty
  property p_rd_top;
    rd_in |=> rdata_out[19:16] == 4'h0;
  endproperty
  property p_ref_period;
    s_ref_rise |-> ##48 s_ref_rise;
  endproperty
  property p_ref_half;
    s_ref_rise |-> ##24 $fell(internal_reference_clock_out);
  endproperty
  a_lock: assert property (p_lock) else $error("clock moved before enable");
  a_inv1: assert property (p_inv1) else $error("first pair not inverse");
  a_inv2: assert property (p_inv2) else $error("second pair not inverse");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  a_rd_top: assert property (p_rd_top) else $error("upper read bits set");
  a_ref_period: assert property (p_ref_period) else $error("reference period wrong");
  a_ref_half: assert property (p_ref_half) else $error("reference half period wrong");
endmodule // sfceg_edge_gen_chk

/* File: tb/sfceg_sensor_model.sv */
// partner: sensor clock pins counting levels and pulses
`timescale 1ns/100ps
module sfceg_sensor_model (
  input wire logic ref_clk_in,
  input wire logic clr_in,
  input wire logic [5:0] pins_in,
  input wire logic [2:0] sel_in,
  output int high_cnt_out,
  output int rise_cnt_out
);
  logic last_reg;
  always @(posedge ref_clk_in) begin
    last_reg <= pins_in[sel_in];
    if (clr_in) begin
      high_cnt_out <= 0;
      rise_cnt_out <= 0;
    end else begin
      high_cnt_out <= high_cnt_out + int'(pins_in[sel_in]);
      if (pins_in[sel_in] && !last_reg) begin
        rise_cnt_out <= rise_cnt_out + 1;
      end
    end
  end
endmodule // sfceg_sensor_model

/* File: tb/tb_top.sv */
// testbench: register access and sensor clock measurement
`timescale 1ns/100ps
module tb_top;
  import sfceg_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [DATA_W-1:0] rdata;
  logic ref_edge;
  logic [5:0] pins;
  logic [1:0] inv;
  int high_cnt;
  int rise_cnt;
  int n_fail = 0;
  int checked = 0;
  logic en_exp = 1'b0;
  int inv_bad = 0;
  // channel, rise, fall, rate code, high cycles and rises per period
  int rows [12][6] = '{'{0, 2, 10, 0, 8, 1}, '{0, 0, 47, 0, 47, 1}, '{0, 3, 9, 1, 12, 2},
    '{0, 23, 5, 1, 12, 2}, '{0, 40, 2, 1, 0, 0}, '{0, 1, 4, 2, 12, 4}, '{1, 0, 6, 2, 24, 4},
    '{1, 2, 14, 3, 12, 1}, '{2, 1, 4, 2, 6, 2}, '{3, 10, 20, 3, 20, 2}, '{4, 30, 6, 0, 24, 1},
    '{5, 5, 20, 0, 15, 1}};
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  sfceg_edge_gen u_sfceg_edge_gen (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .internal_reference_clock_out(ref_edge),
    .phase_clock_one_out(pins[0]), .phase_clock_one_inverted_out(inv[0]), .phase_clock_two_out(pins[1]),
    .phase_clock_two_inverted_out(inv[1]), .last_stage_clock_a_out(pins[2]), .last_stage_clock_b_out(pins[3]),
    .reset_gate_clock_out(pins[4]), .clamp_pulse_clock_out(pins[5]));
  sfceg_sensor_model u_sfceg_sensor_model (.ref_clk_in(ref_clk_in), .clr_in(clr), .pins_in(pins),
    .sel_in(sel), .high_cnt_out(high_cnt), .rise_cnt_out(rise_cnt));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    if (a == CTRL_ADDR) begin
      en_exp = d[CTRL_OUT_EN_BIT];
    end
  endtask
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    chk("rdata", 32'(rdata), 32'(e));
  endtask
  // readback right after the write: a word lost in the bank shows here
  task set_chan(input int ch, input int r, input int f, input int m, input logic [ADDR_W-1:0] base);
    wr_reg(base + ADDR_W'(ch), {6'h00, m[1:0], f[5:0], r[5:0]});
    rd_chk(base + ADDR_W'(ch), {6'h00, m[1:0], f[5:0], r[5:0]});
  endtask
  // settle past a period boundary, then count one full period
  task meas(input int s, input int h, input int r);
    repeat (100) @(posedge ref_clk_in);
    sel <= 3'(s);
    clr <= 1'b1;
    @(posedge ref_clk_in);
    clr <= 1'b0;
    inv_bad = 0;
    repeat (48) begin
      @(posedge ref_clk_in);
      #1;
      if (inv !== (en_exp ? ~pins[1:0] : 2'b00)) begin
        inv_bad++;
      end
    end
    chk("high", high_cnt, h);
    chk("rises", rise_cnt, r);
    chk("inverse", inv_bad, 0);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    meas(0, 0, 0);
    wr_reg(CTRL_ADDR, 20'h00400);
    foreach (rows[i]) begin
      set_chan(rows[i][0], rows[i][1], rows[i][2], rows[i][3], SET_X1_BASE);
      meas(rows[i][0], rows[i][4], rows[i][5]);
    end
    $display("table done");
    set_chan(0, 4, 28, 0, SET_X2_BASE);
    wr_reg(CTRL_ADDR, 20'h00401);
    meas(0, 24, 1);
    rd_chk(10'h3FF, 20'h00000);
    $display("bank and unmapped done");
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    en_exp = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(CTRL_ADDR, CTRL_RESET);
    rd_chk(STATUS_ADDR, 20'h00002);
    meas(0, 0, 0);
    $display("reset done");
    give_verdict();
  end
endmodule // tb_top
bind sfceg_edge_gen sfceg_edge_gen_chk u_sfceg_edge_gen_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .internal_reference_clock_out(internal_reference_clock_out), .phase_clock_one_out(phase_clock_one_out),
  .phase_clock_one_inverted_out(phase_clock_one_inverted_out), .phase_clock_two_out(phase_clock_two_out),
  .phase_clock_two_inverted_out(phase_clock_two_inverted_out), .last_stage_clock_a_out(last_stage_clock_a_out),
  .clamp_pulse_clock_out(clamp_pulse_clock_out));
